//--- sim/tb_top.sv
// Random and directed bench for the timer interrupt router
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
  import tir_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [11:0] bus_addr = 12'h000;
  logic [7:0]  bus_wdata = 8'h00, bus_rdata, host_irq, pend;
  logic [2:0]  timer_out = 3'h0, m;
  logic [3:0]  exp_irq = 4'h0;
  logic        timer_irq;
  int          n_errors = 0, num_checks = 0, seed = 32'h9847, s;
  always #12.5 clk = ~clk;
  tir_router i_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .timer_out(timer_out), .exp_irq(exp_irq),
    .host_irq(host_irq), .timer_irq(timer_irq));
  tir_host_pic i_pic (.clk(clk), .rst(rst), .lines(host_irq), .pend(pend));
  function automatic logic [7:0] line_bit(input logic [2:0] sel);
    return 8'h01 << sel;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 `CHK("rdata", e, bus_rdata)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(TIR_OFS_CONTROL, 8'h00);
    rd(TIR_OFS_STATUS, 8'h00);
    rd(12'hCA5, 8'h00);
    wr(TIR_OFS_CONTROL, 8'hFF);
    rd(TIR_OFS_CONTROL, 8'hF7);
    for (int i = 0; i < 8; i++) begin
      s = $random(seed);
      m = 3'h1 << (s[7:0] % 8'd3);
      wr(TIR_OFS_CONTROL, {1'b1, i[2:0], 1'b0, m});
      @(posedge clk);
      timer_out <= m;
      tick(5);
      `CHK("line", line_bit(i[2:0]), host_irq)
      `CHK("pic", 1'b1, pend[i])
      wr(TIR_OFS_STATUS, 8'h00);
      rd(TIR_OFS_STATUS, {5'h00, m});
      wr(TIR_OFS_STATUS, {5'h00, m});
      `CHK("clear", 8'h00, host_irq)
      // Output still high here: a level must not set the bit again
      tick(4);
      rd(TIR_OFS_STATUS, 8'h00);
      @(posedge clk);
      timer_out <= 3'h0;
    end
    @(posedge clk);
    exp_irq <= 4'hF;
    tick(5);
    `CHK("exp", 8'h0F, host_irq)
    wr(TIR_OFS_CONTROL, 8'h07);
    @(posedge clk);
    exp_irq <= 4'h0;
    timer_out <= 3'h7;
    tick(5);
    `CHK("off", 8'h00, host_irq)
    `CHK("req", 1'b0, timer_irq)
    rd(TIR_OFS_STATUS, 8'h07);
    wr(TIR_OFS_CONTROL, 8'h80);
    `CHK("mask", 1'b0, timer_irq)
    wr(TIR_OFS_CONTROL, 8'hB1);
    `CHK("irq10", 8'h08, host_irq)
    @(posedge clk);
    timer_out <= 3'h0;
    tick(4);
    rd(TIR_OFS_STATUS, 8'h07);
    wr(TIR_OFS_STATUS, 8'h07);
    `CHK("ack", 1'b0, timer_irq)
    tally_and_finish;
  end
endmodule
`default_nettype wire

//--- sim/tir_host_pic.sv
// Host interrupt controller stand-in: latches a rise on each line
`timescale 1ns/10ps
`default_nettype none
module tir_host_pic (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] lines,
  output var  logic [7:0] pend
);
  logic [7:0] prev_r;
  // Edge latch, so a line stuck high is counted once only
  always_ff @(posedge clk) begin
    prev_r <= rst ? 8'h00 : lines;
    pend   <= rst ? 8'h00 : pend | (lines & ~prev_r);
  end
endmodule
`default_nettype wire

//--- sim/tir_router_sva.sv
// Port assertions for the timer interrupt router
`timescale 1ns/10ps
`default_nettype none
module tir_router_sva
  import tir_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic [2:0]  timer_out,
  input wire logic [3:0]  exp_irq,
  input wire logic [7:0]  host_irq,
  input wire logic        timer_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic w_ctl = bus_wr && bus_addr == TIR_OFS_CONTROL;
  wire logic w_st  = bus_wr && bus_addr == TIR_OFS_STATUS;
  wire logic r_ctl = bus_rd && bus_addr == TIR_OFS_CONTROL;
  wire logic r_st  = bus_rd && bus_addr == TIR_OFS_STATUS;
  a_rd_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_ctl_resv: assert property (r_ctl |=> !bus_rdata[3])
    else $error("control bit 3 not zero");
  a_stat_resv: assert property (r_st |=> bus_rdata[7:3] == 5'h00)
    else $error("status upper bits not zero");
  a_unmapped_rd: assert property (bus_rd && !r_ctl && !r_st |=>
    bus_rdata == 8'h00) else $error("unmapped read not zero");
  a_en_off: assert property (w_ctl && !bus_wdata[7] |=>
    !timer_irq && host_irq[7:4] == 4'h0) else $error("request while off");
  a_mask_off: assert property (w_ctl && bus_wdata[2:0] == 3'h0 |=>
    !timer_irq) else $error("request with all masks clear");
  a_clear_drop: assert property ((timer_out == 3'h0)[*3] ##0 w_st &&
    bus_wdata[2:0] == 3'h7 |=> !timer_irq) else $error("clear kept request");
  a_req_routed: assert property (timer_irq |-> host_irq != 8'h00)
    else $error("request on no line");
  a_hi_lines: assert property (host_irq[7:4] != 4'h0 |-> timer_irq &&
    $onehot0(host_irq[7:4])) else $error("bad timer-only line");
  a_exp_or: assert property ((exp_irq == 4'hF)[*3] |=>
    host_irq[3:0] == 4'hF) else $error("expansion request lost");
endmodule
bind tir_router tir_router_sva i_sva (.clk(clk), .rst(rst),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer_out(timer_out),
  .exp_irq(exp_irq), .host_irq(host_irq), .timer_irq(timer_irq));
`default_nettype wire

//--- src/tir_pkg.sv
// Constants and carrier types for the timer interrupt router
package tir_pkg;

  localparam int             TIR_ADDR_W       = 12;
  localparam int             TIR_DATA_W       = 8;
  localparam int             TIR_NUM_TIMERS   = 3;
  localparam int             TIR_NUM_LINES    = 8;
  localparam int             TIR_NUM_SHARED   = 4;
  localparam int             TIR_SEL_W        = 3;

  // Register offsets, as printed
  localparam logic [11:0]    TIR_OFS_CONTROL  = 12'hCA3;
  localparam logic [11:0]    TIR_OFS_STATUS   = 12'hCA4;

  // Control register field positions
  localparam int             TIR_EN_BIT       = 7;
  localparam int             TIR_SEL_HI       = 6;
  localparam int             TIR_SEL_LO       = 4;
  localparam int             TIR_MASK_HI      = 2;
  localparam int             TIR_MASK_LO      = 0;

  // Reset values
  localparam logic           TIR_EN_RST       = 1'h0;
  localparam logic [2:0]     TIR_SEL_RST      = 3'h0;
  localparam logic [2:0]     TIR_MASK_RST     = 3'h0;
  localparam logic [2:0]     TIR_STAT_RST     = 3'h0;
  localparam logic [7:0]     TIR_RD_IDLE      = 8'h00;
  localparam logic [7:0]     TIR_LINES_RST    = 8'h00;

  // Host line select codes; index of the one-hot line output
  typedef enum logic [2:0] {
    TIR_LINE_IRQ3  = 3'h0,
    TIR_LINE_IRQ4  = 3'h1,
    TIR_LINE_IRQ5  = 3'h2,
    TIR_LINE_IRQ10 = 3'h3,
    TIR_LINE_IRQ6  = 3'h4,
    TIR_LINE_IRQ7  = 3'h5,
    TIR_LINE_IRQ9  = 3'h6,
    TIR_LINE_IRQ11 = 3'h7
  } tir_line_t;

  // Software-visible control fields
  typedef struct packed {
    logic      global_request_enable;
    tir_line_t host_line_select;
    logic [2:0] timer_mask;
  } tir_ctrl_t;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } tir_bus_req_t;

endpackage

//--- src/tir_router.sv
// Timer interrupt router: edge capture, status, masking, host line routing
//
// Behaviour
// - Control bit 7 is the global enable; zero blocks every timer request.
// - Three-bit select routes request to IRQ3,4,5,10,6,7,9,11; reset selects IRQ3.
// - With the global enable zero, select is ignored and no line gets a timer request.
// - Control bits 2..0 enable timers five, four, three; one enables.
// - Rising edge on timer five, four, three output sets status bit 2, 1, 0.
// - Writing one clears a status bit; reading returns the captured value.
// - Status bits capture and read back whatever the mask setting.
// - Only low-to-high changes set status; a steady high never re-sets it.
// - Lines IRQ3, IRQ4, IRQ5, IRQ10 carry timer request OR expansion request.
// - Control bit 3 and status bits 7..3 are reserved and hold nothing.
// - A set status bit stays set until software clears it.
`timescale 1ns/10ps
`default_nettype none

module tir_router
  import tir_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [TIR_ADDR_W-1:0]     bus_addr,
  input  wire logic [TIR_DATA_W-1:0]     bus_wdata,
  input  wire logic                      bus_wr,
  input  wire logic                      bus_rd,
  output var  logic [TIR_DATA_W-1:0]     bus_rdata,
  input  wire logic [TIR_NUM_TIMERS-1:0] timer_out,
  input  wire logic [TIR_NUM_SHARED-1:0] exp_irq,
  output var  logic [TIR_NUM_LINES-1:0]  host_irq,
  output var  logic                      timer_irq
);

  // Address match shared by the read and write decode
  function automatic logic tir_hit(input logic [TIR_ADDR_W-1:0] a,
                                   input logic [TIR_ADDR_W-1:0] ofs);
    tir_hit = (a == ofs);
  endfunction

  tir_bus_req_t                 req;
  tir_ctrl_t                    ctrl_r;
  tir_ctrl_t                    ctrl_nxt;
  logic [TIR_NUM_TIMERS-1:0]    stat_r;
  logic [TIR_NUM_TIMERS-1:0]    stat_nxt;
  logic [TIR_NUM_TIMERS-1:0]    tmr_s1_r;
  logic [TIR_NUM_TIMERS-1:0]    tmr_s2_r;
  logic [TIR_NUM_TIMERS-1:0]    tmr_s3_r;
  logic [TIR_NUM_TIMERS-1:0]    tmr_rise;
  logic [TIR_NUM_SHARED-1:0]    exp_s1_r;
  logic [TIR_NUM_SHARED-1:0]    exp_s2_r;
  logic [TIR_DATA_W-1:0]        rdata_r;
  logic [TIR_DATA_W-1:0]        rdata_nxt;
  logic [TIR_NUM_LINES-1:0]     lines_r;
  logic [TIR_NUM_LINES-1:0]     lines_nxt;
  logic [TIR_NUM_LINES-1:0]     line_onehot;
  wire logic [TIR_NUM_LINES-1:0] line_hit;
  logic                         req_r;
  logic                         req_nxt;
  wire logic                    wr_ctrl;
  wire logic                    wr_stat;
  wire logic                    rd_ctrl;
  wire logic                    rd_stat;
  wire logic [TIR_NUM_TIMERS-1:0] clr_bits;
  wire logic [TIR_DATA_W-1:0]   ctrl_view;
  wire logic [TIR_DATA_W-1:0]   stat_view;

  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  // Register decode
  assign wr_ctrl = req.wr && tir_hit(req.addr, TIR_OFS_CONTROL);
  assign wr_stat = req.wr && tir_hit(req.addr, TIR_OFS_STATUS);
  assign rd_ctrl = req.rd && tir_hit(req.addr, TIR_OFS_CONTROL);
  assign rd_stat = req.rd && tir_hit(req.addr, TIR_OFS_STATUS);

  // Reserved control bit and upper status bits read as zero, store nothing
  assign ctrl_view = {ctrl_r.global_request_enable,
                      ctrl_r.host_line_select,
                      1'h0,
                      ctrl_r.timer_mask};
  assign stat_view = {{(TIR_DATA_W-TIR_NUM_TIMERS){1'h0}}, stat_r};

  // Only the three status positions matter; upper written bits are dropped
  assign clr_bits = wr_stat ? req.wdata[TIR_MASK_HI:TIR_MASK_LO]
                            : TIR_STAT_RST;

  // Timer outputs come from another logic region: two-flop synchronise,
  // third flop only for the edge detector so the first stage stays clean
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_s1_r <= '0;
      tmr_s2_r <= '0;
      tmr_s3_r <= '0;
    end else begin
      tmr_s1_r <= timer_out;
      tmr_s2_r <= tmr_s1_r;
      tmr_s3_r <= tmr_s2_r;
    end
  end

  // Expansion requests are levels; two flops are enough, no edge needed
  always_ff @(posedge clk) begin
    if (rst) begin
      exp_s1_r <= '0;
      exp_s2_r <= '0;
    end else begin
      exp_s1_r <= exp_irq;
      exp_s2_r <= exp_s1_r;
    end
  end

  // Per-timer edge capture and sticky status
  genvar g;
  generate
    for (g = 0; g < TIR_NUM_TIMERS; g++) begin : g_tmr
      assign tmr_rise[g] = tmr_s2_r[g] && !tmr_s3_r[g];
      // Set wins over a simultaneous clear so no edge is lost
      assign stat_nxt[g] = tmr_rise[g] ||
                           (stat_r[g] && !clr_bits[g]);
    end
  endgenerate

  // Control register next value
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.global_request_enable = req.wdata[TIR_EN_BIT];
      ctrl_nxt.host_line_select =
        tir_line_t'(req.wdata[TIR_SEL_HI:TIR_SEL_LO]);
      ctrl_nxt.timer_mask = req.wdata[TIR_MASK_HI:TIR_MASK_LO];
    end
  end

  // Combined request uses the next state so the line follows in one cycle
  assign req_nxt = ctrl_nxt.global_request_enable &&
                   |(stat_nxt & ctrl_nxt.timer_mask);

  // One-hot routing; enable off means no line at all
  generate
    for (g = 0; g < TIR_NUM_LINES; g++) begin : g_line
      assign line_hit[g]    = (ctrl_nxt.host_line_select ==
                               tir_line_t'(g));
      assign line_onehot[g] = req_nxt && line_hit[g];
    end
  endgenerate

  // Shared lines merge with the expansion request
  assign lines_nxt = line_onehot |
                     {{(TIR_NUM_LINES-TIR_NUM_SHARED){1'b0}}, exp_s2_r};

  // Read data stands only in the cycle after the strobe
  assign rdata_nxt = rd_ctrl ? ctrl_view :
                     rd_stat ? stat_view : TIR_RD_IDLE;

  // Control register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= '{global_request_enable: TIR_EN_RST,
                  host_line_select:      TIR_LINE_IRQ3,
                  timer_mask:            TIR_MASK_RST};
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Sticky status bits
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_r <= TIR_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Read data register; idles at zero between reads
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= TIR_RD_IDLE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Host lines and combined request, registered so the pins never glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      lines_r <= TIR_LINES_RST;
      req_r   <= 1'h0;
    end else begin
      lines_r <= lines_nxt;
      req_r   <= req_nxt;
    end
  end

  assign bus_rdata = rdata_r;
  assign host_irq  = lines_r;
  assign timer_irq = req_r;

endmodule

`default_nettype wire
